// [design/eepr_defines.svh]
// constants for the serial eeprom slave: widths, counts and timing
`ifndef EEPR_DEFINES_SVH
`define EEPR_DEFINES_SVH

`define EEPR_ADDR_W       16          // array address width
`define EEPR_PAGE_W       6           // page buffer address width
`define EEPR_PAGE_BYTES   7'h40       // bytes in one page
`define EEPR_ACK_SLOT     4'h8        // bit count at the ninth clock
`define EEPR_HALF_BIT     15          // block select sits here
`define EEPR_PTR_STEP     15'h0001    // pointer step within a half
`define EEPR_PAGE_STEP    6'h01       // pointer step within a page
`define EEPR_WR_CYCLES    32'h0000_03E8 // internal write time, clocks
`define EEPR_DEV_CODE     4'h5        // device type code, arbitrary

`endif

// [design/eepr_pkg.sv]
// shared types of the serial eeprom slave
package eepr_pkg;
   `include "eepr_defines.svh"

   // command sequencer states, gray along the write path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CTRL = 3'h1,
      ST_AHI  = 3'h3,
      ST_ALO  = 3'h2,
      ST_WDAT = 3'h6,
      ST_RDAT = 3'h7,
      ST_SKIP = 3'h5
   } eepr_state_t;

   // control byte as received, msb first
   typedef struct packed {
      logic [3:0] code;
      logic       block_select_bit;
      logic [1:0] cs;
      logic       rw;
   } eepr_ctrl_t;

   // pins that arrive from outside the clock domain
   typedef struct packed {
      logic scl;
      logic sda;
      logic wp;
      logic chip_select_high_pin;
      logic chip_select_low_pin;
   } eepr_pins_t;
endpackage

// [design/eepr_sync.sv]
// two-flop synchroniser for the asynchronous pin group
module eepr_sync
   import eepr_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire eepr_pins_t i_pins,
   output eepr_pins_t      o_pins
);
   localparam int W = $bits(eepr_pins_t);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // the first stage feeds only the second; lines idle high
   for (genvar g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            meta_q[g] <= 1'b1;
            sync_q[g] <= 1'b1;
         end else begin
            meta_q[g] <= i_pins[g];
            sync_q[g] <= meta_q[g];
         end
      end
   end

   assign o_pins = sync_q;
endmodule

// [design/eepr_mem.sv]
// byte memory with one write port and a registered read port
`include "eepr_defines.svh"
module eepr_mem #(
   parameter int AW = `EEPR_ADDR_W
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [7:0]    i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic [7:0]         o_rdata
);
   logic [7:0] mem [2**AW];
   logic [7:0] rdata_q;

   // array has no reset; contents are unknown until written
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   // read data always comes out of a register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= mem[i_raddr];
      end
   end

   assign o_rdata = rdata_q;
endmodule

// [design/eepr_top.sv]
// two-wire serial eeprom slave: command sequencer, page buffer, write cycle
// Functional notes
// - write: control byte rw=0, then high, low address and data, each acked.
// - stop after write data starts write cycle; matching control bytes nacked.
// - write protected: commands acked, nothing stored, no busy time.
// - after a byte write the pointer is one past the written byte.
// - up to 63 more bytes go to the page buffer, committed at stop.
// - each data byte bumps only the six low pointer bits.
// - page write past page end wraps to page start.
// - write protect sampled at stop; later changes ignored.
// - master polls with start plus control byte until acked.
// - read control byte has rw=1; current, random, sequential reads.
// - current read acks and sends byte at pointer, last plus one.
// - master ends read with nack and stop; device stops sending.
// - repeated start after address loads pointer, no write cycle.
// - after a random read the pointer is one past the byte read.
// - master ack after a read byte fetches the next byte.
// - sequential read wraps within each half of the array.
// - respond only on matching type code and chip select pins.
// - block bit is top address bit; top address byte msb ignored.
// - after master nack the data line is released high.
`include "eepr_defines.svh"
module eepr_top
   import eepr_pkg::*;
#(
   parameter logic [3:0] P_DEV_CODE  = `EEPR_DEV_CODE, // arbitrary value
   parameter int         P_WR_CYCLES = `EEPR_WR_CYCLES
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda_o,
   output logic      o_sda_oe,
   input  wire logic i_wp,
   input  wire logic i_chip_select_high_pin,
   input  wire logic i_chip_select_low_pin,
   output logic      o_busy
);
   eepr_pins_t  pins_raw;
   eepr_pins_t  s;
   eepr_ctrl_t  rx_ctrl;
   eepr_state_t state_q, state_d;
   logic [3:0]  bit_cnt_q, bit_cnt_d;
   logic        ack_ph_q, ack_ph_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  tx_q, tx_d;
   logic        oe_q, oe_d;
   eepr_ctrl_t  ctrl_q, ctrl_d;
   logic [6:0]  hi_q, hi_d;
   logic [15:0] ptr_q, ptr_d;
   logic        got_q, got_d;
   logic        mack_q, mack_d;
   logic [63:0] mask_q, mask_d;
   logic        scl_p_q, sda_p_q;
   logic        busy_q, busy_d;
   logic [31:0] cnt_q, cnt_d;
   logic [6:0]  cidx_q, cidx_d;
   logic        cvld_q, cvld_d;
   logic [5:0]  cwaddr_q, cwaddr_d;
   logic [9:0]  base_q, base_d;
   logic        scl_rise, scl_fall, start_evt, stop_evt, active;
   logic        ack_slot, ack_done, rd_load, launch, hit;
   logic        pb_we, mem_we;
   logic [7:0]  pb_rdata, mem_rdata;

   assign pins_raw = '{scl: i_scl, sda: i_sda, wp: i_wp,
                       chip_select_high_pin: i_chip_select_high_pin,
                       chip_select_low_pin: i_chip_select_low_pin};

   eepr_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pins  (pins_raw),
      .o_pins  (s)
   );

   // bus events from synchronised lines; scl runs far slower than i_clk
   assign scl_rise  = s.scl & ~scl_p_q;
   assign scl_fall  = ~s.scl & scl_p_q;
   assign start_evt = s.scl & scl_p_q & sda_p_q & ~s.sda;
   assign stop_evt  = s.scl & scl_p_q & ~sda_p_q & s.sda;
   assign active    = !start_evt && !stop_evt && state_q != ST_IDLE
                      && state_q != ST_SKIP;
   assign ack_slot  = active && scl_fall && bit_cnt_q == `EEPR_ACK_SLOT
                      && !ack_ph_q;
   assign ack_done  = active && scl_fall && ack_ph_q;
   assign rd_load   = ack_done && ((state_q == ST_CTRL && ctrl_q.rw)
                      || (state_q == ST_RDAT && mack_q));
   assign rx_ctrl   = shift_q;
   // busy device nacks every addressed control byte, the polling one too
   assign hit       = rx_ctrl.code == P_DEV_CODE && !busy_q
                      && rx_ctrl.cs == {s.chip_select_high_pin,
                                        s.chip_select_low_pin};
   // wp taken from the stop itself, so later toggles cannot matter
   assign launch    = stop_evt && state_q == ST_WDAT && got_q && !busy_q
                      && !s.wp;

   // command sequencer: start and stop first, then scl edges
   always_comb begin
      state_d   = state_q;
      bit_cnt_d = bit_cnt_q;
      ack_ph_d  = ack_ph_q;
      shift_d   = shift_q;
      tx_d      = tx_q;
      oe_d      = oe_q;
      ctrl_d    = ctrl_q;
      hi_d      = hi_q;
      ptr_d     = ptr_q;
      got_d     = got_q;
      mack_d    = mack_q;
      mask_d    = mask_q;
      pb_we     = 1'b0;
      if (start_evt) begin
         state_d   = ST_CTRL;
         bit_cnt_d = 4'h0;
         ack_ph_d  = 1'b0;
         oe_d      = 1'b0;
         got_d     = 1'b0;
      end else if (stop_evt) begin
         state_d   = ST_IDLE;
         bit_cnt_d = 4'h0;
         ack_ph_d  = 1'b0;
         oe_d      = 1'b0;
         got_d     = 1'b0;
      end else if (active && scl_rise) begin
         if (bit_cnt_q < `EEPR_ACK_SLOT) begin
            shift_d   = {shift_q[6:0], s.sda};
            bit_cnt_d = bit_cnt_q + 4'h1;
         end else if (ack_ph_q) begin
            mack_d = ~s.sda;
         end
      end else if (ack_slot) begin
         ack_ph_d = 1'b1;
         mack_d   = 1'b0;
         case (state_q)
            ST_CTRL: begin
               if (hit) begin
                  oe_d   = 1'b1;
                  ctrl_d = rx_ctrl;
                  if (rx_ctrl.rw) begin
                     ptr_d[`EEPR_HALF_BIT] = rx_ctrl.block_select_bit;
                  end
               end else begin
                  state_d = ST_SKIP;
               end
            end
            ST_AHI: begin
               hi_d = shift_q[6:0];
               oe_d = 1'b1;
            end
            ST_ALO: begin
               ptr_d  = {ctrl_q.block_select_bit, hi_q, shift_q};
               mask_d = '0;
               oe_d   = 1'b1;
            end
            ST_WDAT: begin
               pb_we                = 1'b1;
               mask_d[ptr_q[5:0]]   = 1'b1;
               ptr_d[5:0]           = ptr_q[5:0] + `EEPR_PAGE_STEP;
               got_d                = 1'b1;
               oe_d                 = 1'b1;
            end
            default: begin
               oe_d = 1'b0;               // release for master ack
            end
         endcase
      end else if (ack_done) begin
         ack_ph_d  = 1'b0;
         bit_cnt_d = 4'h0;
         oe_d      = 1'b0;
         case (state_q)
            ST_CTRL: state_d = ctrl_q.rw ? ST_RDAT : ST_AHI;
            ST_AHI:  state_d = ST_ALO;
            ST_ALO:  state_d = ST_WDAT;
            ST_RDAT: state_d = mack_q ? ST_RDAT : ST_SKIP;
            default: state_d = state_q;
         endcase
         if (rd_load) begin
            tx_d  = mem_rdata;
            oe_d  = ~mem_rdata[7];
            ptr_d = {ptr_q[`EEPR_HALF_BIT],
                     ptr_q[14:0] + `EEPR_PTR_STEP};
         end
      end else if (active && scl_fall && state_q == ST_RDAT) begin
         tx_d = {tx_q[6:0], 1'b0};
         oe_d = ~tx_q[6];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         ack_ph_q  <= 1'b0;
         shift_q   <= 8'h00;
         tx_q      <= 8'h00;
         oe_q      <= 1'b0;
         ctrl_q    <= '0;
         hi_q      <= 7'h00;
         ptr_q     <= 16'h0000;
         got_q     <= 1'b0;
         mack_q    <= 1'b0;
         mask_q    <= '0;
         scl_p_q   <= 1'b1;
         sda_p_q   <= 1'b1;
      end else begin
         state_q   <= state_d;
         bit_cnt_q <= bit_cnt_d;
         ack_ph_q  <= ack_ph_d;
         shift_q   <= shift_d;
         tx_q      <= tx_d;
         oe_q      <= oe_d;
         ctrl_q    <= ctrl_d;
         hi_q      <= hi_d;
         ptr_q     <= ptr_d;
         got_q     <= got_d;
         mack_q    <= mack_d;
         mask_q    <= mask_d;
         scl_p_q   <= s.scl;
         sda_p_q   <= s.sda;
      end
   end

   // write cycle: copy marked buffer bytes, then hold busy for the full time
   always_comb begin
      busy_d   = busy_q;
      cnt_d    = cnt_q;
      cidx_d   = cidx_q;
      cvld_d   = 1'b0;
      cwaddr_d = cwaddr_q;
      base_d   = base_q;
      if (launch) begin
         busy_d = 1'b1;
         cnt_d  = 32'h0000_0000;
         cidx_d = 7'h00;
         base_d = ptr_q[15:6];
      end else if (busy_q) begin
         cnt_d = cnt_q + 32'h0000_0001;
         if (cidx_q < `EEPR_PAGE_BYTES) begin
            cvld_d   = 1'b1;
            cwaddr_d = cidx_q[5:0];
            cidx_d   = cidx_q + 7'h01;
         end
         if (cnt_q == 32'(P_WR_CYCLES - 1)) begin
            busy_d = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_q   <= 1'b0;
         cnt_q    <= 32'h0000_0000;
         cidx_q   <= 7'h00;
         cvld_q   <= 1'b0;
         cwaddr_q <= 6'h00;
         base_q   <= 10'h000;
      end else begin
         busy_q   <= busy_d;
         cnt_q    <= cnt_d;
         cidx_q   <= cidx_d;
         cvld_q   <= cvld_d;
         cwaddr_q <= cwaddr_d;
         base_q   <= base_d;
      end
   end

   // only bytes received since the address are committed
   assign mem_we = cvld_q && mask_q[cwaddr_q];

   eepr_mem #(.AW(`EEPR_PAGE_W)) u_page (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_we    (pb_we),
      .i_waddr (ptr_q[5:0]),
      .i_wdata (shift_q),
      .i_raddr (cidx_q[5:0]),
      .o_rdata (pb_rdata)
   );

   // array read follows the pointer, ready long before the next scl fall
   eepr_mem #(.AW(`EEPR_ADDR_W)) u_array (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_we    (mem_we),
      .i_waddr ({base_q, cwaddr_q}),
      .i_wdata (pb_rdata),
      .i_raddr (ptr_q),
      .o_rdata (mem_rdata)
   );

   assign o_sda_o  = 1'b0;   // open drain: only ever pulls low
   assign o_sda_oe = oe_q;
   assign o_busy   = busy_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_wr_byte;
      ack_slot && state_q == ST_WDAT;
   endsequence
   sequence s_addr_byte;
      ack_slot && (state_q == ST_AHI || state_q == ST_ALO);
   endsequence
   sequence s_rd_nack;
      ack_done && state_q == ST_RDAT && !mack_q;
   endsequence

   AST_PAGE_WRAP: assert property (s_wr_byte |=>
      ptr_q[5:0] == $past(ptr_q[5:0]) + `EEPR_PAGE_STEP
      && ptr_q[15:6] == $past(ptr_q[15:6]))
      else $error("page pointer step wrong");
   AST_ADDR_ACK: assert property ((s_addr_byte or s_wr_byte) |=>
      o_sda_oe ##1 o_sda_oe)
      else $error("address or data byte not acked");
   AST_BUSY_NACK: assert property (
      busy_q && ack_slot && state_q == ST_CTRL |=> !o_sda_oe)
      else $error("control byte acked while busy");
   AST_WP_NOCYCLE: assert property (
      stop_evt && state_q == ST_WDAT && got_q && s.wp && !busy_q
      |=> !busy_q && state_q == ST_IDLE)
      else $error("protected write started a cycle");
   AST_LAUNCH: assert property (
      launch |=> busy_q && base_q == $past(ptr_q[15:6]))
      else $error("write cycle not launched at stop");
   AST_HALF_WRAP: assert property (rd_load |=>
      ptr_q[15] == $past(ptr_q[15])
      && ptr_q[14:0] == $past(ptr_q[14:0]) + `EEPR_PTR_STEP)
      else $error("read pointer left its half");
   AST_RD_RELEASE: assert property (s_rd_nack |=>
      state_q == ST_SKIP && !o_sda_oe)
      else $error("line not released after master nack");
   AST_START_ABORT: assert property (start_evt |=>
      state_q == ST_CTRL && bit_cnt_q == 4'h0 && !o_sda_oe)
      else $error("start did not restart the command");
   AST_DEV_MISS: assert property (
      ack_slot && state_q == ST_CTRL && shift_q[7:4] != P_DEV_CODE
      |=> !o_sda_oe && state_q == ST_SKIP)
      else $error("foreign control byte acked");
   AST_BUSY_HOLD: assert property ($rose(busy_q) |-> busy_q[*8])
      else $error("write cycle too short");
   AST_BUSY_END: assert property ($fell(busy_q) |->
      $past(cnt_q) == 32'(P_WR_CYCLES - 1))
      else $error("write cycle ended off its count");
   AST_WR_IN_CYCLE: assert property (mem_we |-> busy_q)
      else $error("array written outside write cycle");
   AST_ALO_PTR: assert property (
      ack_slot && state_q == ST_ALO |=>
      ptr_q == {ctrl_q.block_select_bit, $past(hi_q), $past(shift_q)})
      else $error("address pointer load wrong");
endmodule

// [verification/eepr_mst_model.sv]
// two-wire bus master model: drives the clock and pulls data low
module eepr_mst_model (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle: clock high, data released to the pull-up
   initial begin
      o_scl    = 1'h1;
      o_sda_oe = 1'h0;
   end

   // all pin changes land on falling edges of the system clock
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // one bit: data moves mid-low, is sampled mid-high, 20 clocks a bit
   task automatic bit_slot(input logic v, output logic s);
      tick(5);
      o_sda_oe = ~v;
      tick(5);
      o_scl = 1'h1;
      tick(5);
      s = i_sda;
      tick(5);
      o_scl = 1'h0;
   endtask

   // start or repeated start: data falls while the clock is high
   task automatic start();
      tick(5);
      o_sda_oe = 1'h0;
      tick(5);
      o_scl = 1'h1;
      tick(5);
      o_sda_oe = 1'h1;
      tick(5);
      o_scl = 1'h0;
   endtask

   // stop: data rises while the clock is high; clock then stands high
   task automatic stop();
      tick(5);
      o_sda_oe = 1'h1;
      tick(5);
      o_scl = 1'h1;
      tick(5);
      o_sda_oe = 1'h0;
      tick(5);
   endtask

   // byte out msb first, ninth slot released to read the acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], s);
      end
      bit_slot(1'h1, s);
      ack = ~s;
   endtask

   // byte in; ack asks for the next byte, nack ends the read
   task automatic recv(input logic mack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'h1, s);
         b[i] = s;
      end
      bit_slot(~mack, s);
   endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the serial eeprom slave
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0]  DEV    = 4'h5;       // type code, arbitrary
   localparam int          WR_CYC = 400;        // short write time
   localparam logic [23:0] BAD    = 24'h10_0402; // code, cs high, cs low
   logic       clk;
   logic       rst_n;
   logic       scl;
   logic       m_oe;
   logic       d_oe;
   logic       d_o;
   logic       wp;
   logic [1:0] cs_pin;
   logic       busy;
   logic       sda;
   logic       ack;
   logic [7:0] rdat;
   int         miscompares = 0;
   int         checks = 0;

   // open-drain wire with a pull-up; the device drives only its pin value
   assign sda = ~m_oe & (d_oe ? d_o : 1'h1);

   eepr_top #(.P_DEV_CODE(DEV), .P_WR_CYCLES(WR_CYC)) dut (
      .i_clk                  (clk),
      .i_rst_n                (rst_n),
      .i_scl                  (scl),
      .i_sda                  (sda),
      .o_sda_o                (d_o),
      .o_sda_oe               (d_oe),
      .i_wp                   (wp),
      .i_chip_select_high_pin (cs_pin[1]),
      .i_chip_select_low_pin  (cs_pin[0]),
      .o_busy                 (busy)
   );

   eepr_mst_model u_mst (
      .i_clk    (clk),
      .i_sda    (sda),
      .o_scl    (scl),
      .o_sda_oe (m_oe)
   );

   // 125 MHz system clock
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // control byte: code, block bit, chip selects matching the pins, rw
   function automatic logic [7:0] cb(input logic blk, input logic rw);
      return {DEV, blk, 2'h2, rw};
   endfunction

   // start, control byte, both address bytes; high byte msb set on purpose
   task automatic set_addr(input logic [15:0] a);
      u_mst.start();
      u_mst.send(cb(a[15], 1'h0), ack);
      chk(8'(ack), 8'h01);
      u_mst.send({1'h1, a[14:8]}, ack);
      chk(8'(ack), 8'h01);
      u_mst.send(a[7:0], ack);
      chk(8'(ack), 8'h01);
   endtask

   // acknowledge polling with the control byte that began the write
   task automatic poll(input logic blk, output int n);
      n = 0;
      ack = 1'h0;
      while (ack !== 1'h1 && n < 20) begin
         u_mst.start();
         u_mst.send(cb(blk, 1'h0), ack);
         if (ack !== 1'h1) n++;
      end
      u_mst.stop();
   endtask

   // write n bytes d, d+1..; flip toggles protect right after the stop
   task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d,
                     input logic flip);
      logic p;
      int   k;
      set_addr(a);
      for (int i = 0; i < n; i++) begin
         u_mst.send(d + 8'(i), ack);
         chk(8'(ack), 8'h01);
      end
      p = wp;
      u_mst.stop();
      if (flip) wp = ~wp;
      chk(8'(busy), 8'(!p));
      poll(a[15], k);
      chk(8'(k != 0), 8'(!p));
      chk(8'(ack), 8'h01);
   endtask

   // random read when rnd is set, else current read; up to four bytes
   task automatic rd_chk(input logic rnd, input logic [15:0] a,
                         input int n, input logic [31:0] e);
      if (rnd) set_addr(a);
      u_mst.start();
      u_mst.send(cb(a[15], 1'h1), ack);
      chk(8'(ack), 8'h01);
      for (int i = 0; i < n; i++) begin
         u_mst.recv(i < n - 1, rdat);
         chk(rdat, e[31-8*i -: 8]);
      end
      chk(8'(d_oe), 8'h00);
      u_mst.stop();
      chk(8'(busy), 8'h00);
   endtask

   task automatic print_verdict();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      int n;
      rst_n = 1'h0;
      wp = 1'h0;
      cs_pin = 2'h2;
      repeat (16) @(negedge clk);
      rst_n = 1'h1;
      repeat (4) @(negedge clk);
      // wrong type code or chip selects get no acknowledge
      for (int i = 0; i < 3; i++) begin
         u_mst.start();
         u_mst.send(cb(1'h0, 1'h0) ^ BAD[8*i +: 8], ack);
         chk(8'(ack), 8'h00);
         u_mst.stop();
      end
      // pins moved: the old select bits miss, the new ones hit
      cs_pin = 2'h1;
      u_mst.start();
      u_mst.send(cb(1'h0, 1'h0), ack);
      chk(8'(ack), 8'h00);
      u_mst.start();
      u_mst.send({DEV, 3'h1, 1'h0}, ack);
      chk(8'(ack), 8'h01);
      u_mst.stop();
      cs_pin = 2'h2;
      wr(16'h0200, 4, 8'h10, 1'h0);
      wr(16'h0201, 1, 8'hEE, 1'h0);
      rd_chk(1'h0, 16'h0000, 1, 32'h1200_0000);
      rd_chk(1'h1, 16'h0201, 1, 32'hEE00_0000);
      rd_chk(1'h0, 16'h0000, 1, 32'h1200_0000);
      // protected write is acked but stores nothing
      wp = 1'h1;
      wr(16'h0201, 1, 8'h77, 1'h1);
      rd_chk(1'h1, 16'h0201, 1, 32'hEE00_0000);
      // protect raised after the stop does not stop the write
      wr(16'h0203, 1, 8'h99, 1'h1);
      wp = 1'h0;
      rd_chk(1'h1, 16'h0203, 1, 32'h9900_0000);
      // 66 bytes from 013E: wraps in the page, last two overwrite
      wr(16'h013E, 66, 8'h00, 1'h0);
      rd_chk(1'h1, 16'h013C, 4, 32'h3E3F_4041);
      // sequential read wraps inside each half
      for (int h = 0; h < 2; h++) begin
         wr({h[0], 15'h7FFF}, 1, 8'h3C, 1'h0);
         wr({h[0], 15'h0000}, 1, 8'hC3, 1'h0);
         rd_chk(1'h1, {h[0], 15'h7FFF}, 2, 32'h3CC3_0000);
      end
      // stop in mid-byte still commits the full byte before it
      set_addr(16'h0204);
      u_mst.send(8'h44, ack);
      for (int i = 0; i < 3; i++) begin
         u_mst.bit_slot(1'h0, ack);
      end
      u_mst.stop();
      chk(8'(busy), 8'h01);
      poll(1'h0, n);
      rd_chk(1'h1, 16'h0204, 1, 32'h4400_0000);
      print_verdict();
   end

   // watchdog: the tests need a little under half this span
   initial begin
      repeat (80000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule
